// ==== ast_sample_ctl.sv ====
// sample timing source selection and axis-ordered fifo fill
// assumes register port strobes are one-cycle and synchronous to clk_sys
// How it works
// - external clock mode takes pin one as input; untriggered sample timing counts its rising edges
// - external trigger mode: each pin two rising edge in measure mode while no sample is being pushed yields one sample
// - external trigger mode without trigger keeps converter idle, no samples
// - fifo filled in strict x, y, z order per sample
// - mode field: 00 standby, 01 wake-up, 10 instant on, 11 measure
// - fifo data read pops one word, high byte first, address stays put
`timescale 1ns/1ps
module ast_sample_ctl #(
  parameter int INT_DIV = ast_pkg::INT_DIV_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic irq_pin_one_in,
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe,
  input wire logic irq_pin_two_in,
  input wire logic [ast_pkg::AXIS_W-1:0] adc_x,
  input wire logic [ast_pkg::AXIS_W-1:0] adc_y,
  input wire logic [ast_pkg::AXIS_W-1:0] adc_z,
  output logic adc_enable
);
  // ==========================================================
  // configuration registers
  logic [7:0] timing_r, timing_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [1:0] fifo_mode_r, fifo_mode_nxt;
  logic trig_sel, xclk_sel, measure;
  logic [2:0] odr;

  assign trig_sel = timing_r[ast_pkg::TIM_TRIG_SEL_BIT];
  assign xclk_sel = timing_r[ast_pkg::TIM_XCLK_SEL_BIT];
  assign odr = timing_r[ast_pkg::TIM_ODR_LSB +: 3];
  assign measure = (mode_r == ast_pkg::MODE_MEASURE);

  always_comb
  begin
    timing_nxt = timing_r;
    mode_nxt = mode_r;
    fifo_mode_nxt = fifo_mode_r;
    if (reg_wr_en)
    begin
      case (reg_addr)
        ast_pkg::ADDR_TIMING: timing_nxt = reg_wdata;
        ast_pkg::ADDR_POWER: mode_nxt = reg_wdata[1:0];
        ast_pkg::ADDR_FIFO_CTL: fifo_mode_nxt = reg_wdata[1:0];
        default: timing_nxt = timing_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      timing_r <= ast_pkg::TIMING_RESET;
      mode_r <= ast_pkg::POWER_RESET;
      fifo_mode_r <= ast_pkg::FIFO_CTL_RESET;
    end
    else
    begin
      timing_r <= timing_nxt;
      mode_r <= mode_nxt;
      fifo_mode_r <= fifo_mode_nxt;
    end
  end

  // ==========================================================
  // sample timebase: system clock or pin one edges, trigger on pin two
  logic one_prev_r, two_prev_r;
  logic [12:0] tick_cnt_r, tick_cnt_nxt;
  logic [12:0] tick_lim;
  logic step, tick, trig, start;

  assign tick_lim = 13'(INT_DIV >> odr);
  assign step = xclk_sel ? (irq_pin_one_in && !one_prev_r) : 1'b1;
  assign trig = irq_pin_two_in && !two_prev_r;
  assign start = measure && (trig_sel ? trig : tick);

  always_comb
  begin
    tick = 1'b0;
    tick_cnt_nxt = tick_cnt_r;
    if (!measure || trig_sel)
      tick_cnt_nxt = '0;
    else if (step)
    begin
      if (tick_cnt_r + 13'h0001 >= tick_lim)
      begin
        tick = 1'b1;
        tick_cnt_nxt = '0;
      end
      else
        tick_cnt_nxt = tick_cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      one_prev_r <= 1'b0;
      two_prev_r <= 1'b0;
      tick_cnt_r <= '0;
    end
    else
    begin
      one_prev_r <= irq_pin_one_in;
      two_prev_r <= irq_pin_two_in;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // ==========================================================
  // capture one sample and push x, y, z in order
  ast_pkg::ast_state_t st_r, st_nxt;
  ast_pkg::ast_axis_t axis_r, axis_nxt;
  logic [ast_pkg::AXIS_W-1:0] sx_r, sy_r, sz_r, sx_nxt, sy_nxt, sz_nxt;
  logic [ast_pkg::AXIS_W-1:0] cur_axis;
  logic push_v, push_rdy, flush;
  logic [ast_pkg::WORD_W-1:0] push_word;

  assign flush = (fifo_mode_r == ast_pkg::FIFO_BYPASS);
  assign push_v = (st_r == ast_pkg::ST_PUSH) && !flush;
  assign push_word = {cur_axis, 4'h0};

  always_comb
  begin
    case (axis_r)
      ast_pkg::AXIS_X: cur_axis = sx_r;
      ast_pkg::AXIS_Y: cur_axis = sy_r;
      default: cur_axis = sz_r;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    axis_nxt = axis_r;
    sx_nxt = sx_r;
    sy_nxt = sy_r;
    sz_nxt = sz_r;
    case (st_r)
      ast_pkg::ST_IDLE:
        if (start)
        begin
          sx_nxt = adc_x;
          sy_nxt = adc_y;
          sz_nxt = adc_z;
          axis_nxt = ast_pkg::AXIS_X;
          st_nxt = ast_pkg::ST_PUSH;
        end
      ast_pkg::ST_PUSH:
        if (flush)
          st_nxt = ast_pkg::ST_IDLE; // a sample cut by bypass is dropped whole
        else if (push_rdy)
        begin
          case (axis_r)
            ast_pkg::AXIS_X: axis_nxt = ast_pkg::AXIS_Y;
            ast_pkg::AXIS_Y: axis_nxt = ast_pkg::AXIS_Z;
            default:
            begin
              axis_nxt = ast_pkg::AXIS_X;
              st_nxt = ast_pkg::ST_IDLE;
            end
          endcase
        end
      default: st_nxt = ast_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= ast_pkg::ST_IDLE;
      axis_r <= ast_pkg::AXIS_X;
      sx_r <= '0;
      sy_r <= '0;
      sz_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      axis_r <= axis_nxt;
      sx_r <= sx_nxt;
      sy_r <= sy_nxt;
      sz_r <= sz_nxt;
    end
  end

  // ==========================================================
  // fifo instance
  logic pop_rdy, head_v;
  logic [ast_pkg::WORD_W-1:0] head;
  logic [4:0] level;

  ast_fifo #(.WIDTH(ast_pkg::WORD_W), .DEPTH(ast_pkg::FIFO_WORDS)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .flush(flush),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_word),
    .out_valid(head_v),
    .out_ready(pop_rdy),
    .out_data(head),
    .level(level)
  );

  // ==========================================================
  // register read, fifo byte pairing, pin drivers
  logic [7:0] rdata_r, rdata_nxt, lsb_r, lsb_nxt;
  logic phase_r, phase_nxt;
  logic one_out_r, one_out_nxt, one_oe_r, one_oe_nxt, adc_en_r, adc_en_nxt;

  assign reg_rdata = rdata_r;
  assign irq_pin_one_out = one_out_r;
  assign irq_pin_one_oe = one_oe_r;
  assign adc_enable = adc_en_r;

  always_comb
  begin
    rdata_nxt = rdata_r;
    lsb_nxt = lsb_r;
    phase_nxt = phase_r;
    pop_rdy = 1'b0;
    if (reg_rd_en)
    begin
      case (reg_addr)
        ast_pkg::ADDR_FIFO_DATA:
          if (phase_r)
          begin
            rdata_nxt = lsb_r;
            phase_nxt = 1'b0;
          end
          else if (head_v)
          begin
            pop_rdy = 1'b1;
            rdata_nxt = head[15:8];
            lsb_nxt = head[7:0];
            phase_nxt = 1'b1;
          end
          else
            rdata_nxt = 8'h00;
        ast_pkg::ADDR_TIMING: rdata_nxt = timing_r;
        ast_pkg::ADDR_POWER: rdata_nxt = {6'h00, mode_r};
        ast_pkg::ADDR_FIFO_CTL: rdata_nxt = {level, 1'b0, fifo_mode_r};
        ast_pkg::ADDR_REVISION: rdata_nxt = ast_pkg::REVISION_CODE;
        default: rdata_nxt = 8'h00;
      endcase
    end
    one_out_nxt = (level == 5'(ast_pkg::FIFO_WORDS)); // fifo full flag on pin one
    one_oe_nxt = !xclk_sel;
    adc_en_nxt = measure && (!trig_sel || trig);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r <= 8'h00;
      lsb_r <= 8'h00;
      phase_r <= 1'b0;
      one_out_r <= 1'b0;
      one_oe_r <= 1'b1;
      adc_en_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      lsb_r <= lsb_nxt;
      phase_r <= phase_nxt;
      one_out_r <= one_out_nxt;
      one_oe_r <= one_oe_nxt;
      adc_en_r <= adc_en_nxt;
    end
  end

  chk_xclk_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    xclk_sel |=> !irq_pin_one_oe)
    else $error("pin one driven in external clock mode");
  chk_sync_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    trig_sel && !trig && st_r == ast_pkg::ST_IDLE |=> st_r == ast_pkg::ST_IDLE && !adc_enable)
    else $error("sample taken without trigger");
  chk_trig_sample: assert property (@(posedge clk_sys) disable iff (!nrst)
    measure && trig_sel && trig && st_r == ast_pkg::ST_IDLE |=> st_r == ast_pkg::ST_PUSH && axis_r == ast_pkg::AXIS_X)
    else $error("trigger did not start a sample");
  chk_axis_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    push_v && push_rdy && axis_r == ast_pkg::AXIS_X |=> axis_r == ast_pkg::AXIS_Y)
    else $error("axis order broken");
  chk_mode_standby: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode_r != ast_pkg::MODE_MEASURE && st_r == ast_pkg::ST_IDLE |=> st_r == ast_pkg::ST_IDLE)
    else $error("sampling outside measurement mode");
  chk_pop_msb: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd_en && reg_addr == ast_pkg::ADDR_FIFO_DATA && !phase_r && head_v
    |=> reg_rdata == $past(head[15:8]) && phase_r)
    else $error("fifo high byte wrong");
  chk_pop_lsb: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd_en && reg_addr == ast_pkg::ADDR_FIFO_DATA && phase_r |=> reg_rdata == $past(lsb_r) && !phase_r)
    else $error("fifo low byte wrong");
  chk_bypass_empty: assert property (@(posedge clk_sys) disable iff (!nrst)
    flush |=> level == 5'h00)
    else $error("bypass left data in fifo");
endmodule : ast_sample_ctl

// ==== ast_pkg.sv ====
// package for the accelerometer sample timing and fifo ordering block
// assumes a byte-wide register port and one 20 MHz system clock
package ast_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_REVISION = 8'h01;
  localparam logic [7:0] ADDR_FIFO_CTL = 8'h3a;
  localparam logic [7:0] ADDR_TIMING = 8'h3d;
  localparam logic [7:0] ADDR_POWER = 8'h3f;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h42;
  // ==========================================================
  // field positions and reset values
  localparam int TIM_TRIG_SEL_BIT = 0;
  localparam int TIM_XCLK_SEL_BIT = 1;
  localparam int TIM_ODR_LSB = 5;
  localparam logic [7:0] TIMING_RESET = 8'h00;
  localparam logic [1:0] POWER_RESET = 2'h0;
  localparam logic [1:0] FIFO_CTL_RESET = 2'h0;
  // silicon revision code: value is arbitrary
  localparam logic [7:0] REVISION_CODE = 8'h5a;
  // ==========================================================
  // mode encodings
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKEUP = 2'h1;
  localparam logic [1:0] MODE_INSTANT_ON = 2'h2;
  localparam logic [1:0] MODE_MEASURE = 2'h3;
  localparam logic [1:0] FIFO_BYPASS = 2'h0;
  // ==========================================================
  // sizes and timing
  localparam int AXIS_W = 12;
  localparam int WORD_W = 16;
  localparam int FIFO_WORDS = 16;
  localparam int CLK_HZ = 20000000;
  localparam int SENSOR_ODR_HZ = 2560;
  localparam int INT_DIV_CYC = CLK_HZ / SENSOR_ODR_HZ;
  // ==========================================================
  // types
  typedef enum logic [1:0] {AXIS_X, AXIS_Y, AXIS_Z} ast_axis_t;
  typedef enum logic {ST_IDLE, ST_PUSH} ast_state_t;
endpackage : ast_pkg

// ==== ast_fifo.sv ====
// flip-flop fifo with valid/ready on both sides and a flush input
// assumes one clock and asynchronous active-low reset
`timescale 1ns/1ps
module ast_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // ==========================================================
  // pointer and count update; flush empties the store
  assign in_ready = (cnt_r != (PW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign level = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  always_comb
  begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (flush)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (push)
        wp_nxt = wp_r + 1'b1;
      if (pop)
        rp_nxt = rp_r + 1'b1;
      cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // storage entries, one per index
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_ent
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          mem_r[gi] <= '0;
        else if (push && wp_r == PW'(gi))
          mem_r[gi] <= in_data;
      end
    end
  endgenerate

  chk_flush_empty: assert property (@(posedge clk_sys) disable iff (!nrst)
    flush |=> (cnt_r == '0) && !out_valid)
    else $error("fifo not empty after flush");
  chk_full_stall: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cnt_r == (PW+1)'(DEPTH)) && !pop |=> cnt_r == (PW+1)'(DEPTH) || $past(flush))
    else $error("full fifo lost or gained words");
endmodule : ast_fifo

// ==== ast_host_model.sv ====
// host and pin-side partner: register strobes, trigger pin, external clock, converter values
// assumes the register port and pin split of ast_sample_ctl, one 20 MHz clock
`timescale 1ns/1ps
module ast_host_model #(
  parameter logic [11:0] X_VAL = 12'h123,
  parameter logic [11:0] Y_VAL = 12'h456,
  parameter logic [11:0] Z_VAL = 12'h789
) (
  input wire logic clk_sys,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic pin1_out,
  input wire logic pin1_oe,
  output logic pin1_wire,
  output logic pin2,
  output logic [ast_pkg::AXIS_W-1:0] adc_x,
  output logic [ast_pkg::AXIS_W-1:0] adc_y,
  output logic [ast_pkg::AXIS_W-1:0] adc_z
);
  logic clk_en;
  logic clk_lvl;
  // ==========================================================
  // pin one: device drive, else host clock, else pull-up
  assign pin1_wire = pin1_oe ? pin1_out : (clk_en ? clk_lvl : 1'b1);
  // idle values at time zero
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pin2 = 1'b0;
    clk_en = 1'b0;
    clk_lvl = 1'b0;
    adc_x = X_VAL;
    adc_y = Y_VAL;
    adc_z = Z_VAL;
  end
  // ==========================================================
  // register port cycles, strobe held until the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a; // released address no longer shows the last one
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask : rd
  // ==========================================================
  // one trigger activation on pin two
  task automatic trig();
    @(posedge clk_sys);
    #1;
    pin2 = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    pin2 = 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : trig
  // n external clock periods on pin one; the line stands low between bursts
  task automatic run_xclk(input int n);
    clk_en = 1'b1;
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk_sys);
      #1;
      clk_lvl = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      clk_lvl = 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : run_xclk
endmodule : ast_host_model

// ==== testbench.sv ====
// self-checking bench for ast_sample_ctl with the host partner model
// assumes INT_DIV shortened to 8 and fixed converter values per axis
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] AX = 12'h123;
  localparam logic [11:0] AY = 12'h456;
  localparam logic [11:0] AZ = 12'h789;
  logic clk_sys, nrst, wr_en, rd_en, p1_out, p1_oe, p1_wire, p2, adc_en;
  logic [7:0] addr, wdata, rdata, d;
  logic [11:0] ax, ay, az;
  logic [4:0] lv;
  int n_mismatch = 0;
  int n_tests = 0;
  // ==========================================================
  // design and partner
  ast_sample_ctl #(.INT_DIV(8)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .irq_pin_one_in(p1_wire), .irq_pin_one_out(p1_out),
    .irq_pin_one_oe(p1_oe), .irq_pin_two_in(p2), .adc_x(ax), .adc_y(ay), .adc_z(az), .adc_enable(adc_en));
  ast_host_model #(.X_VAL(AX), .Y_VAL(AY), .Z_VAL(AZ)) host_u (.clk_sys(clk_sys), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .pin1_out(p1_out),
    .pin1_oe(p1_oe), .pin1_wire(p1_wire), .pin2(p2), .adc_x(ax), .adc_y(ay), .adc_z(az));
  // 50 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk
  task automatic rd_lvl(output logic [4:0] v);
    logic [7:0] r;
    host_u.rd(ast_pkg::ADDR_FIFO_CTL, r);
    v = r[7:3];
  endtask : rd_lvl
  // pops words and compares them with the repeating x, y, z pattern
  task automatic drain(input int n);
    logic [7:0] h, l;
    for (int k = 0; k < n; k++)
    begin
      host_u.rd(ast_pkg::ADDR_FIFO_DATA, h);
      host_u.rd(ast_pkg::ADDR_FIFO_DATA, l);
      chk("fifo word", (k % 3 == 0) ? {AX, 4'h0} : (k % 3 == 1) ? {AY, 4'h0} : {AZ, 4'h0}, {h, l});
    end
  endtask : drain
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("pin one enable", 16'h1, {15'h0, p1_oe});
    chk("converter enable", 16'h0, {15'h0, adc_en});
    host_u.rd(ast_pkg::ADDR_TIMING, d);
    chk("timing reset", {8'h0, ast_pkg::TIMING_RESET}, {8'h0, d});
    host_u.rd(8'h55, d);
    chk("unmapped read", 16'h0, {8'h0, d});
    host_u.rd(ast_pkg::ADDR_REVISION, d);
    chk("revision", {8'h0, ast_pkg::REVISION_CODE}, {8'h0, d});
    host_u.wr(ast_pkg::ADDR_TIMING, 8'ha2);
    host_u.rd(ast_pkg::ADDR_TIMING, d);
    chk("timing readback", 16'h00a2, {8'h0, d});
    host_u.wr(ast_pkg::ADDR_TIMING, 8'h00);
  endtask : t_reset
  task automatic t_modes();
    host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      host_u.wr(ast_pkg::ADDR_POWER, 8'(m));
      repeat (40) @(posedge clk_sys);
      rd_lvl(lv);
      chk("sampling per mode", {15'h0, m == 3}, {15'h0, lv != 5'h0});
      host_u.wr(ast_pkg::ADDR_POWER, 8'h00);
      host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h00);
      rd_lvl(lv);
      chk("bypass empties", 16'h0, {11'h0, lv});
      host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h01);
    end
  endtask : t_modes
  task automatic t_sync();
    host_u.wr(ast_pkg::ADDR_TIMING, 8'h01);
    host_u.wr(ast_pkg::ADDR_POWER, 8'h03);
    repeat (40) @(posedge clk_sys);
    chk("converter idle", 16'h0, {15'h0, adc_en});
    rd_lvl(lv);
    chk("no trigger level", 16'h0, {11'h0, lv});
    for (int k = 1; k < 3; k++)
    begin
      host_u.trig();
      rd_lvl(lv);
      chk("trigger level", 16'(3 * k), {11'h0, lv});
    end
    drain(6);
    host_u.rd(ast_pkg::ADDR_FIFO_DATA, d);
    chk("empty fifo read", 16'h0, {8'h0, d});
  endtask : t_sync
  task automatic t_loop();
    int w;
    host_u.wr(ast_pkg::ADDR_TIMING, 8'h00);
    w = 0;
    while (p1_out !== 1'b1 && w < 400)
    begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    chk("fifo full on pin one", 16'h1, {15'h0, p1_out});
    chk("converter running", 16'h1, {15'h0, adc_en});
    host_u.wr(ast_pkg::ADDR_TIMING, 8'h01);
    drain(ast_pkg::FIFO_WORDS);
    host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h00);
    rd_lvl(lv);
    chk("bypass clear", 16'h0, {11'h0, lv});
    host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h01);
    chk("full cleared", 16'h0, {15'h0, p1_out});
  endtask : t_loop
  task automatic t_extclk();
    host_u.run_xclk(0);
    host_u.wr(ast_pkg::ADDR_TIMING, 8'h22);
    host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h00);
    host_u.wr(ast_pkg::ADDR_FIFO_CTL, 8'h01);
    chk("pin one released", 16'h0, {15'h0, p1_oe});
    repeat (40) @(posedge clk_sys);
    rd_lvl(lv);
    chk("still clock level", 16'h0, {11'h0, lv});
    host_u.run_xclk(8);
    repeat (6) @(posedge clk_sys);
    rd_lvl(lv);
    chk("external clock level", 16'h6, {11'h0, lv});
    host_u.wr(ast_pkg::ADDR_TIMING, 8'h00);
    @(posedge clk_sys);
    #1;
    chk("pin one driven", 16'h1, {15'h0, p1_oe});
  endtask : t_extclk
  // ==========================================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_reset();
    t_modes();
    t_sync();
    t_loop();
    t_extclk();
    give_verdict();
  end
  // watchdog, over thirty times the expected run
  initial
  begin
    #(50 * 20000);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
